// File: rtl/io_timer_pkg.sv
// Constants, register map and carrier types of the ten-channel io_timer
package io_timer_pkg;

  localparam int          NUM_CH        = 10;
  localparam int          TRANSFER_CH   = 8;

  // Register indices; byte address is four times the index
  localparam logic [31:0] CH0_COUNTER_IDX    = 32'h0080_0300;
  localparam logic [31:0] CH0_RELOAD_ONE_IDX = 32'h0080_0304;
  localparam logic [31:0] CH0_RELOAD_ZERO_IDX = 32'h0080_0306;
  localparam logic [31:0] CH0_CONTROL_IDX    = 32'h0080_0308;
  localparam logic [31:0] CH_STRIDE_IDX      = 32'h0000_0010;
  localparam logic [31:0] ENABLE_IDX         = 32'h0080_03C0;
  localparam logic [31:0] STATUS_IDX         = 32'h0080_03C4;
  localparam logic [31:0] PRESCALE_IDX       = 32'h0080_03C8;

  // Control and status register fields
  localparam int          CTL_MODE_LSB  = 0;
  localparam int          CTL_TRIG_LSB  = 3;
  localparam int          CTL_EXT_BIT   = 6;
  localparam int          STATUS_FF_LSB = 16;

  // Reset and restart values
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] MEASURE_TOP   = 16'hFFFF;
  localparam logic [7:0]  PRESCALE_RESET = 8'h00;

  // Mode field encoding
  localparam logic [2:0]  MODE_SINGLE   = 3'h0;
  localparam logic [2:0]  MODE_DELAYED  = 3'h1;
  localparam logic [2:0]  MODE_CONT     = 3'h2;
  localparam logic [2:0]  MODE_PWM      = 3'h3;
  localparam logic [2:0]  MODE_MEAS_CLR = 3'h4;
  localparam logic [2:0]  MODE_MEAS_RUN = 3'h5;

  // External trigger select encoding
  localparam logic [2:0]  TRIG_OFF      = 3'h0;
  localparam logic [2:0]  TRIG_RISE     = 3'h1;
  localparam logic [2:0]  TRIG_FALL     = 3'h2;
  localparam logic [2:0]  TRIG_BOTH     = 3'h3;
  localparam logic [2:0]  TRIG_HIGH     = 3'h4;
  localparam logic [2:0]  TRIG_LOW      = 3'h5;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] reload_one;
    logic [15:0] reload_zero;
    logic [2:0]  mode;
    logic [2:0]  trig;
    logic        ext_en;
    logic        en;
    logic        pend;
    logic        out_ff;
    logic        phase;
    logic        paused;
    logic        irq;
    logic        dma;
    logic        sync1;
    logic        sync2;
    logic        prev;
  } chan_type;

  typedef struct packed {
    chan_type [NUM_CH-1:0] ch;
    logic [7:0]            presc;
    logic [7:0]            div;
    logic                  tick;
    apb_rsp_type           rsp;
  } state_type;

endpackage : io_timer_pkg

// File: rtl/io_timer.sv
// Ten-channel 16-bit input/output timer with APB register access
`timescale 1ns/1ps

module io_timer (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire io_timer_pkg::apb_req_type  apb_in,
  output      io_timer_pkg::apb_rsp_type  apb_out,
  input  wire logic [io_timer_pkg::NUM_CH-1:0] timer_in,
  output      logic [io_timer_pkg::NUM_CH-1:0] timer_out,
  output      logic [io_timer_pkg::NUM_CH-1:0] irq_req,
  output      logic                       transfer_req
);
  import io_timer_pkg::*;

  state_type s_reg;
  state_type s_next;

  function automatic logic [31:0] byte_addr(input logic [31:0] idx);
    return {idx[29:0], 2'b00};
  endfunction : byte_addr

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    chan_type    c;
    logic        first;
    logic        acc_wr;
    logic        hit;
    logic        hit_en;
    logic [31:0] rdata;
    logic [31:0] ofs;
    logic        rise;
    logic        fall;
    logic        edge_ev;
    logic        lvl_ok;
    logic        trig_ev;
    logic        uf;
    s_next = s_reg;
    c      = '0;
    rdata  = '0;
    hit    = 1'b0;
    hit_en = 1'b0;
    ofs    = '0;
    rise   = 1'b0;
    fall   = 1'b0;
    edge_ev = 1'b0;
    lvl_ok = 1'b0;
    trig_ev = 1'b0;
    uf     = 1'b0;
    first  = apb_in.psel & apb_in.penable & ~s_reg.rsp.pready;
    acc_wr = apb_in.psel & apb_in.penable & s_reg.rsp.pready
             & apb_in.pwrite;

    // Count clock: one tick every presc+1 bus clocks
    if (s_reg.div >= s_reg.presc) begin
      s_next.div  = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.div  = s_reg.div + 8'h01;
      s_next.tick = 1'b0;
    end

    // Global register decode
    if (apb_in.paddr == byte_addr(ENABLE_IDX)) begin
      hit    = 1'b1;
      hit_en = 1'b1;
      for (int i = 0; i < NUM_CH; i++) begin
        rdata[i] = s_reg.ch[i].en;
      end
    end else if (apb_in.paddr == byte_addr(STATUS_IDX)) begin
      hit = 1'b1;
      for (int i = 0; i < NUM_CH; i++) begin
        rdata[i] = s_reg.ch[i].en & ~s_reg.ch[i].pend;
        rdata[STATUS_FF_LSB+i] = s_reg.ch[i].out_ff;
      end
    end else if (apb_in.paddr == byte_addr(PRESCALE_IDX)) begin
      hit   = 1'b1;
      rdata = {24'h000000, s_reg.presc};
      if (acc_wr) begin
        s_next.presc = apb_in.pwdata[7:0];
      end
    end

    for (int i = 0; i < NUM_CH; i++) begin
      c       = s_reg.ch[i];
      c.irq   = 1'b0;
      c.dma   = 1'b0;
      // Pin synchroniser; edges only from the second stage onward
      c.sync1 = timer_in[i];
      c.sync2 = s_reg.ch[i].sync1;
      c.prev  = s_reg.ch[i].sync2;
      rise    = s_reg.ch[i].sync2 & ~s_reg.ch[i].prev;
      fall    = ~s_reg.ch[i].sync2 & s_reg.ch[i].prev;
      case (s_reg.ch[i].trig)
        TRIG_RISE: edge_ev = rise;
        TRIG_FALL: edge_ev = fall;
        TRIG_BOTH: edge_ev = rise | fall;
        default:   edge_ev = 1'b0;
      endcase
      if (s_reg.ch[i].trig == TRIG_HIGH) begin
        lvl_ok = s_reg.ch[i].sync2;
      end else if (s_reg.ch[i].trig == TRIG_LOW) begin
        lvl_ok = ~s_reg.ch[i].sync2;
      end else begin
        lvl_ok = 1'b0;
      end
      trig_ev = edge_ev | lvl_ok;
      uf = (s_reg.ch[i].cnt == 16'h0000);

      // Start of operation, taken on a count clock tick
      if (s_reg.tick && s_reg.ch[i].en && s_reg.ch[i].pend) begin
        c.pend = 1'b0;
        c.phase = 1'b0;
        case (s_reg.ch[i].mode)
          MODE_SINGLE: begin
            c.cnt    = s_reg.ch[i].reload_zero;
            c.out_ff = ~s_reg.ch[i].out_ff;
          end
          MODE_PWM: begin
            c.cnt    = s_reg.ch[i].reload_zero;
            c.out_ff = ~s_reg.ch[i].out_ff;
          end
          MODE_CONT: begin
            c.out_ff = ~s_reg.ch[i].out_ff;
          end
          MODE_DELAYED, MODE_MEAS_CLR, MODE_MEAS_RUN: begin
            c.cnt = s_reg.ch[i].cnt;
          end
          default: begin
            c.cnt    = s_reg.ch[i].reload_zero;
            c.paused = 1'b0;
          end
        endcase
      end else if (s_reg.tick && s_reg.ch[i].en) begin
        // Running on a count clock tick
        case (s_reg.ch[i].mode)
          MODE_MEAS_CLR, MODE_MEAS_RUN: begin
            if (uf) begin
              c.cnt = MEASURE_TOP;
              c.irq = 1'b1;
              c.dma = 1'b1;
            end else begin
              c.cnt = s_reg.ch[i].cnt - 16'h0001;
            end
          end
          MODE_SINGLE: begin
            if (uf) begin
              c.out_ff = ~s_reg.ch[i].out_ff;
              c.en     = 1'b0;
              c.irq    = 1'b1;
              c.dma    = 1'b1;
            end else begin
              c.cnt = s_reg.ch[i].cnt - 16'h0001;
            end
          end
          MODE_DELAYED: begin
            if (uf) begin
              c.out_ff = ~s_reg.ch[i].out_ff;
              c.irq    = 1'b1;
              c.dma    = 1'b1;
              if (!s_reg.ch[i].phase) begin
                c.cnt   = s_reg.ch[i].reload_zero;
                c.phase = 1'b1;
              end else begin
                c.en = 1'b0;
              end
            end else begin
              c.cnt = s_reg.ch[i].cnt - 16'h0001;
            end
          end
          MODE_CONT: begin
            if (uf) begin
              c.cnt    = s_reg.ch[i].reload_zero;
              c.out_ff = ~s_reg.ch[i].out_ff;
              c.irq    = 1'b1;
              c.dma    = 1'b1;
            end else begin
              c.cnt = s_reg.ch[i].cnt - 16'h0001;
            end
          end
          MODE_PWM: begin
            if (uf) begin
              c.out_ff = ~s_reg.ch[i].out_ff;
              c.dma    = 1'b1;
              c.phase  = ~s_reg.ch[i].phase;
              if (!s_reg.ch[i].phase) begin
                c.cnt = s_reg.ch[i].reload_one;
              end else begin
                c.cnt = s_reg.ch[i].reload_zero;
                c.irq = 1'b1;
              end
            end else begin
              c.cnt = s_reg.ch[i].cnt - 16'h0001;
            end
          end
          default: begin
            if (!lvl_ok) begin
              c.paused = 1'b1;
            end else if (s_reg.ch[i].paused) begin
              c.cnt    = s_reg.ch[i].reload_zero;
              c.paused = 1'b0;
            end else if (uf) begin
              c.en  = 1'b0;
              c.irq = 1'b1;
              c.dma = 1'b1;
            end else begin
              c.cnt = s_reg.ch[i].cnt - 16'h0001;
            end
          end
        endcase
      end

      // Capture in measure modes
      if (s_reg.ch[i].en && s_reg.ch[i].mode[2:1] == 2'b10
          && edge_ev) begin
        c.reload_zero = s_reg.ch[i].cnt;
        c.irq         = 1'b1;
        if (s_reg.ch[i].mode == MODE_MEAS_CLR && s_reg.ch[i].ext_en) begin
          c.cnt = MEASURE_TOP;
        end
      end

      // External start of a stopped channel
      if (!s_reg.ch[i].en && s_reg.ch[i].ext_en && trig_ev
          && s_reg.ch[i].mode[2:1] != 2'b10) begin
        c.en   = 1'b1;
        c.pend = 1'b1;
      end

      // Per-channel register decode
      ofs = CH_STRIDE_IDX * 32'(i);
      if (apb_in.paddr == byte_addr(CH0_COUNTER_IDX + ofs)) begin
        hit   = 1'b1;
        rdata = {16'h0000, s_reg.ch[i].cnt};
        if (acc_wr) begin
          c.cnt = apb_in.pwdata[15:0];
        end
      end else if (apb_in.paddr == byte_addr(CH0_RELOAD_ONE_IDX + ofs)) begin
        hit   = 1'b1;
        rdata = {16'h0000, s_reg.ch[i].reload_one};
        if (acc_wr) begin
          c.reload_one = apb_in.pwdata[15:0];
        end
      end else if (apb_in.paddr == byte_addr(CH0_RELOAD_ZERO_IDX + ofs)) begin
        hit   = 1'b1;
        rdata = {16'h0000, s_reg.ch[i].reload_zero};
        if (acc_wr) begin
          c.reload_zero = apb_in.pwdata[15:0];
        end
      end else if (apb_in.paddr == byte_addr(CH0_CONTROL_IDX + ofs)) begin
        hit   = 1'b1;
        rdata = {25'h0000000, s_reg.ch[i].ext_en, s_reg.ch[i].trig,
                 s_reg.ch[i].mode};
        if (acc_wr) begin
          c.mode   = apb_in.pwdata[CTL_MODE_LSB +: 3];
          c.trig   = apb_in.pwdata[CTL_TRIG_LSB +: 3];
          c.ext_en = apb_in.pwdata[CTL_EXT_BIT];
        end
      end

      // Software enable write overrides external start; a write of one to a running channel does not undo a hardware stop
      if (acc_wr && hit_en) begin
        if (apb_in.pwdata[i] && !s_reg.ch[i].en) begin
          c.en   = 1'b1;
          c.pend = 1'b1;
        end else if (!apb_in.pwdata[i]) begin
          c.en     = 1'b0;
          c.pend   = 1'b0;
          c.paused = 1'b0;
        end
      end

      if (i != TRANSFER_CH) begin
        c.dma = 1'b0;
      end
      s_next.ch[i] = c;
    end

    // APB answer: one wait state, data and error registered
    s_next.rsp.pready  = first;
    s_next.rsp.pslverr = first & ~hit;
    s_next.rsp.prdata  = (first && !apb_in.pwrite && hit) ? rdata : '0;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg       <= '0;
      s_reg.presc <= PRESCALE_RESET;
      for (int i = 0; i < NUM_CH; i++) begin
        s_reg.ch[i].cnt <= COUNT_RESET;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign apb_out      = s_reg.rsp;
  assign transfer_req = s_reg.ch[TRANSFER_CH].dma;

  for (genvar g = 0; g < NUM_CH; g++) begin : gen_out
    assign timer_out[g] = s_reg.ch[g].out_ff;
    assign irq_req[g]   = s_reg.ch[g].irq;
  end

endmodule : io_timer

// File: bench/io_timer_properties.sv
// Port assertions of the io_timer block
`timescale 1ns/1ps
module io_timer_properties (
  input wire logic                            pclk,
  input wire logic                            presetn,
  input wire io_timer_pkg::apb_req_type       apb_in,
  input wire io_timer_pkg::apb_rsp_type       apb_out,
  input wire logic [io_timer_pkg::NUM_CH-1:0] timer_in,
  input wire logic [io_timer_pkg::NUM_CH-1:0] timer_out,
  input wire logic [io_timer_pkg::NUM_CH-1:0] irq_req,
  input wire logic                            transfer_req
);
  import io_timer_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    apb_in.psel && !apb_in.penable;
  endsequence
  sequence s_wait;
    apb_in.psel && apb_in.penable && !apb_out.pready;
  endsequence
  property p_answer;
    s_setup ##1 s_wait |=> apb_out.pready;
  endproperty
  property p_ready_pulse;
    apb_out.pready |=> !apb_out.pready;
  endproperty
  property p_ready_in_xfer;
    apb_out.pready |-> apb_in.psel && apb_in.penable;
  endproperty
  property p_err_data;
    apb_out.pslverr |-> apb_out.pready && apb_out.prdata == 32'h0;
  endproperty
  property p_rdata_idle;
    !apb_out.pready |-> apb_out.prdata == 32'h0;
  endproperty
  property p_setup_quiet;
    s_setup |-> !apb_out.pready;
  endproperty
  property p_reset_out;
    $rose(presetn) |-> timer_out == '0 && irq_req == '0 && !transfer_req;
  endproperty
  property p_upper_zero;
    apb_out.pready && !apb_in.pwrite
      && apb_in.paddr == (CH0_RELOAD_ONE_IDX << 2)
      |-> apb_out.prdata[31:16] == 16'h0;
  endproperty
  property p_unmapped;
    apb_out.pready && apb_in.paddr == 32'h0 |-> apb_out.pslverr;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no answer in second access cycle");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_ready_in_xfer: assert property (p_ready_in_xfer)
    else $error("pready outside a transfer");
  a_err_data: assert property (p_err_data)
    else $error("slave error without pready or with data");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero while idle");
  a_setup_quiet: assert property (p_setup_quiet)
    else $error("pready in setup cycle");
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not low after reset");
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper half of a 16-bit register not zero");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address without slave error");
endmodule : io_timer_properties

// File: bench/io_timer_pin_model.sv
// Partner model of the external enable and capture pins
`timescale 1ns/1ps
module io_timer_pin_model (
  input  wire logic                            pclk,
  input  wire logic                            fire,
  input  wire logic [3:0]                      fire_ch,
  output      logic [io_timer_pkg::NUM_CH-1:0] pins
);
  import io_timer_pkg::*;
  int hold = 0;
  initial pins = '0;
  // Pulse held four clocks so the synchroniser sees both edges
  always @(posedge pclk) begin
    if (fire) begin
      pins[fire_ch] <= 1'b1;
      hold <= 4;
    end else if (hold > 0) begin
      hold <= hold - 1;
      if (hold == 1) pins <= '0;
    end
  end
endmodule : io_timer_pin_model

// File: bench/io_timer_tb_top.sv
// Self-checking testbench of the io_timer block
`timescale 1ns/1ps
module io_timer_tb_top;
  import io_timer_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              fire;
  logic [3:0]        fire_ch;
  logic              tr;
  logic              err;
  apb_req_type       req;
  apb_rsp_type       rsp;
  logic [NUM_CH-1:0] pins;
  logic [NUM_CH-1:0] tout;
  logic [NUM_CH-1:0] irq;
  logic [31:0]       seed = 32'h5B09C390;
  logic [31:0]       rd;
  logic [31:0]       v;
  logic [31:0]       a;
  logic [31:0]       b;
  logic [31:0]       exp_q[$];
  logic [31:0]       msk_q[$];
  int                bad_count = 0;
  int                check_count = 0;
  int                n;
  int                tr_n;
  int                irq_n[NUM_CH];

  io_timer i_io_timer (.pclk(pclk), .presetn(presetn), .apb_in(req),
    .apb_out(rsp), .timer_in(pins), .timer_out(tout), .irq_req(irq),
    .transfer_req(tr));
  io_timer_pin_model i_io_timer_pin_model (.pclk(pclk), .fire(fire),
    .fire_ch(fire_ch), .pins(pins));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function logic [31:0] ra(input logic [31:0] idx, input int c);
    return (idx + CH_STRIDE_IDX * c) << 2;
  endfunction : ra

  task check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  task apb(input logic w, input logic [31:0] adr, d);
    int k;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, adr, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task rdq(input logic [31:0] adr, e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, adr, 32'h0);
  endtask : rdq

  task arm(input int c, input logic [6:0] ctl, input logic [15:0] cn, r0);
    apb(1'b1, ra(CH0_COUNTER_IDX, c), {16'h0, cn});
    apb(1'b1, ra(CH0_RELOAD_ZERO_IDX, c), {16'h0, r0});
    apb(1'b1, ra(CH0_RELOAD_ONE_IDX, c), {16'h0, b[15:0]});
    apb(1'b1, ra(CH0_CONTROL_IDX, c), {25'h0, ctl});
    foreach (irq_n[i]) irq_n[i] = 0;
    tr_n = 0;
    apb(1'b1, ENABLE_IDX << 2, 32'h1 << c);
  endtask : arm

  task gap(input int c, lim);
    logic p;
    p = tout[c];
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tout[c] === p && n < lim);
  endtask : gap

  // Read results are compared in order against the noted expectations
  always @(posedge pclk) begin
    if (rsp.pready === 1'b1 && req.psel === 1'b1 && req.pwrite === 1'b0
        && exp_q.size() > 0)
      check("read data", rsp.prdata & msk_q.pop_front(), exp_q.pop_front());
    foreach (irq_n[i]) irq_n[i] += int'(irq[i]);
    tr_n += int'(tr);
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    test_done;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    req = '0;
    fire = 1'b0;
    fire_ch = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    v = rnd();
    // Periods of at least nine ticks keep the disable write clear of the
    // next underflow in the continuous and PWM runs
    a = 32'h8 + v[2:0];
    b = 32'h8 + v[5:3];
    rdq(ra(CH0_COUNTER_IDX, 5), 32'h0, 32'hFFFFFFFF);
    apb(1'b1, ra(CH0_RELOAD_ONE_IDX, 3), v);
    rdq(ra(CH0_RELOAD_ONE_IDX, 3), {16'h0, v[15:0]}, 32'hFFFFFFFF);
    apb(1'b0, 32'h0, 32'h0);
    check("slave error", {31'h0, err}, 32'h1);
    $display("registers done");
    arm(0, {4'h0, MODE_SINGLE}, 16'h0, a[15:0]);
    gap(0, 50);
    gap(0, 50);
    check("single pulse", 32'(n), a + 32'h1);
    gap(0, 30);
    check("single stop", 32'(n), 32'd30);
    check("single irq", 32'(irq_n[0]), 32'h1);
    rdq(ENABLE_IDX << 2, 32'h0, 32'h1);
    rdq(STATUS_IDX << 2, 32'h0, 32'h0001_0000);
    $display("single done");
    arm(2, {4'h0, MODE_DELAYED}, b[15:0], a[15:0]);
    gap(2, 60);
    gap(2, 50);
    check("delayed pulse", 32'(n), a + 32'h1);
    gap(2, 30);
    check("delayed stop", 32'(n), 32'd30);
    check("delayed irq", 32'(irq_n[2]), 32'h2);
    check("delayed transfer", 32'(tr_n), 32'h0);
    $display("delayed done");
    for (int m = 0; m < 2; m++) begin
      arm(8, {4'h0, m == 0 ? MODE_CONT : MODE_PWM}, b[15:0], a[15:0]);
      gap(8, 50);
      gap(8, 50);
      check("gap one", 32'(n), (m == 0 ? b : a) + 32'h1);
      gap(8, 50);
      check("gap two", 32'(n), (m == 0 ? a : b) + 32'h1);
      gap(8, 50);
      check("gap three", 32'(n), a + 32'h1);
      apb(1'b1, ENABLE_IDX << 2, 32'h0);
      gap(8, 20);
      check("stopped", 32'(n), 32'd20);
      check("irq count", 32'(irq_n[8]), m == 0 ? 32'h3 : 32'h1);
      check("transfer count", 32'(tr_n), 32'h3);
    end
    $display("continuous and pwm done");
    apb(1'b1, PRESCALE_IDX << 2, 32'hFF);
    arm(0, {1'b1, TRIG_RISE, MODE_MEAS_CLR}, 16'h1000, 16'h0);
    repeat (600) @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (20) @(posedge pclk);
    rdq(ra(CH0_COUNTER_IDX, 0), 32'hFFFE, 32'hFFFE);
    rdq(ra(CH0_RELOAD_ZERO_IDX, 0), 32'h0FF8, 32'hFFF8);
    check("capture irq", 32'(irq_n[0]), 32'h1);
    apb(1'b1, ENABLE_IDX << 2, 32'h0);
    $display("measure done");
    // Noise mode: paused while low, reloaded on the high level, then stops
    apb(1'b1, PRESCALE_IDX << 2, 32'h0);
    arm(3, {1'b0, TRIG_HIGH, 3'h6}, 16'h0, 16'h1);
    repeat (10) @(posedge pclk);
    fire_ch <= 4'h3;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (20) @(posedge pclk);
    check("noise irq", 32'(irq_n[3]), 32'h1);
    rdq(ENABLE_IDX << 2, 32'h0, 32'h8);
    $display("noise done");
    test_done;
  end
endmodule : io_timer_tb_top

bind io_timer io_timer_properties i_io_timer_properties (.pclk(pclk),
  .presetn(presetn), .apb_in(apb_in), .apb_out(apb_out),
  .timer_in(timer_in), .timer_out(timer_out), .irq_req(irq_req),
  .transfer_req(transfer_req));
